// file: core/ipm_pkg.sv
/*
 Constants, register indices and carrier types for the posted-flag and
 unmask register block of a small microcontroller interrupt controller.
 Assumes one system clock shared by the bus, the sources and the CPU.
*/
// Function
// R1 - Flag read shows posted state per bit
// R2 - Zero write clears flag when soft-post off
// R3 - One write keeps flag when soft-post off
// R4 - One write posts flag when soft-post on
// R5 - Cleared unmask bit blocks pending, posting continues
// R6 - Set unmask bit passes posted as pending
// R7 - Each unmask bit governs only its source
// R8 - Flags B: bits 6..0 timers, bus, endpoints
// R9 - Flags C: bits 4, 2, 1 used
// R10 - Unmask B mirrors flags B layout
// R11 - Unmask C mirrors flags C layout
// R12 - Soft-post control holds enable bit 7 only
// R13 - Pending vector goes to the priority encoder
// R14 - Flag holds until taken or cleared
// R15 - Reserved bits zero; zero writes ignored when soft-post
`default_nettype none

package ipm_pkg;

    localparam int IDX_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_POSTED_B = 10'h0DB;
    localparam logic [9:0] IDX_POSTED_C = 10'h0DC;
    localparam logic [9:0] IDX_SOFT_CTRL = 10'h0DE;
    localparam logic [9:0] IDX_UNMASK_C = 10'h0DF;
    localparam logic [9:0] IDX_UNMASK_B = 10'h0E1;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0E4;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0E5;

    // Implemented bits of each register
    localparam logic [7:0] USED_B = 8'h7F;
    localparam logic [7:0] USED_C = 8'h16;
    localparam logic [7:0] USED_SOFT = 8'h80;
    localparam logic [7:0] USED_IRQ = 8'h03;
    localparam int SOFT_POST_EN_BIT = 7;

    // Flag C bit positions
    localparam int C_COUNTER_WRAP_BIT = 1;
    localparam int C_EXTERNAL_LINE_TWO_BIT = 2;
    localparam int C_GPIO_PORT2_BIT = 4;

    // Interrupt status bits: a new post landed in flags B or C
    localparam int IRQ_POST_B_BIT = 0;
    localparam int IRQ_POST_C_BIT = 1;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One bit per source, in the same layout as the flag registers
    typedef struct packed {
        logic [7:0] b;
        logic [7:0] c;
    } ipm_flags_t;

endpackage : ipm_pkg

`default_nettype wire

// file: core/ipm_regs.sv
/*
 Posted-flag registers B and C, unmask registers B and C, the soft-post
 control register and a small interrupt status/mask pair, all behind an
 AXI4-Lite slave. Assumes the post strobes and take strobes come from logic
 on the same clock, and that the priority encoder and global enable sit
 outside and read the pending vector.
*/
// Our own choice: the AXI4-Lite register port.
`default_nettype none

module ipm_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic clk,                          // System clock
    input wire logic rstn,                         // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr,    // Write address
    input wire logic s_axi_awvalid,                // Write address valid
    output logic s_axi_awready,                    // Write address ready
    input wire logic [31:0] s_axi_wdata,           // Write data
    input wire logic [3:0] s_axi_wstrb,            // Write byte strobes
    input wire logic s_axi_wvalid,                 // Write data valid
    output logic s_axi_wready,                     // Write data ready
    output logic [1:0] s_axi_bresp,                // Write response
    output logic s_axi_bvalid,                     // Write response valid
    input wire logic s_axi_bready,                 // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr,    // Read address
    input wire logic s_axi_arvalid,                // Read address valid
    output logic s_axi_arready,                    // Read address ready
    output logic [31:0] s_axi_rdata,               // Read data
    output logic [1:0] s_axi_rresp,                // Read response
    output logic s_axi_rvalid,                     // Read data valid
    input wire logic s_axi_rready,                 // Read data ready
    input wire ipm_pkg::ipm_flags_t hwPost,        // Source post strobes
    input wire ipm_pkg::ipm_flags_t cpuTake,       // CPU took this interrupt
    output var ipm_pkg::ipm_flags_t pending,       // Pending vector to encoder
    output logic irq                               // Block interrupt, level
);

    logic awReady_q;
    logic wReady_q;
    logic bValid_q;
    logic [1:0] bResp_q;
    logic arReady_q;
    logic rValid_q;
    logic [1:0] rResp_q;
    logic [7:0] rData_q;
    logic [7:0] postedB_q;
    logic [7:0] postedC_q;
    logic [7:0] postedB_d;
    logic [7:0] postedC_d;
    logic [7:0] unmaskB_q;
    logic [7:0] unmaskC_q;
    logic softPostEn_q;
    logic [7:0] irqStatus_q;
    logic [7:0] irqStatus_d;
    logic [7:0] irqMask_q;
    ipm_pkg::ipm_flags_t pending_q;
    logic irq_q;

    logic wrFire;
    logic wrDo;
    logic rdFire;
    logic rdDo;
    logic [ipm_pkg::IDX_W-1:0] wrIdx;
    logic [ipm_pkg::IDX_W-1:0] rdIdx;
    logic [7:0] wrByte;
    logic wrLane;
    logic wrB;
    logic wrC;
    logic wrHit;
    logic rdHit;
    logic [7:0] rdByte;

    // Next state of one flag register. Hardware posts are applied last, so a
    // post in the same cycle as a clear or a take is never lost.
    function automatic logic [7:0] post_next(
        input logic [7:0] cur,
        input logic [7:0] hw,
        input logic [7:0] take,
        input logic [7:0] wd,
        input logic [7:0] used,
        input logic wr,
        input logic swEn
    );
        logic [7:0] keep;
        logic [7:0] set;
        keep = cur & ~take;                        // see R14
        set = hw;
        if (wr && !swEn) begin
            keep = keep & wd;                      // see R2 see R3
        end
        if (wr && swEn) begin
            set = set | wd;                        // see R4 see R15
        end
        return (keep | set) & used;                // see R15
    endfunction : post_next

    function automatic logic idx_known(input logic [ipm_pkg::IDX_W-1:0] idx);
        return idx == ipm_pkg::IDX_POSTED_B || idx == ipm_pkg::IDX_POSTED_C ||
               idx == ipm_pkg::IDX_SOFT_CTRL || idx == ipm_pkg::IDX_UNMASK_C ||
               idx == ipm_pkg::IDX_UNMASK_B || idx == ipm_pkg::IDX_IRQ_STATUS ||
               idx == ipm_pkg::IDX_IRQ_MASK;
    endfunction : idx_known

    // Address and data are taken together; upper address bits are not
    // decoded, so the map aliases every 4 KiB.
    assign wrIdx = s_axi_awaddr[ipm_pkg::IDX_W+1:2];
    assign rdIdx = s_axi_araddr[ipm_pkg::IDX_W+1:2];
    assign wrByte = s_axi_wdata[7:0];
    assign wrLane = s_axi_wstrb[0];
    assign wrFire = s_axi_awvalid && s_axi_wvalid && !awReady_q && !bValid_q;
    assign wrDo = s_axi_awvalid && awReady_q && s_axi_wvalid && wReady_q;
    assign rdFire = s_axi_arvalid && !arReady_q && !rValid_q;
    assign rdDo = s_axi_arvalid && arReady_q;
    assign wrHit = idx_known(wrIdx);
    assign rdHit = idx_known(rdIdx);
    assign wrB = wrDo && wrLane && wrIdx == ipm_pkg::IDX_POSTED_B;
    assign wrC = wrDo && wrLane && wrIdx == ipm_pkg::IDX_POSTED_C;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            awReady_q <= 1'b0;
            wReady_q <= 1'b0;
            bValid_q <= 1'b0;
            bResp_q <= ipm_pkg::RESP_OKAY;
        end else begin
            awReady_q <= wrFire;
            wReady_q <= wrFire;
            if (wrDo) begin
                bValid_q <= 1'b1;
                bResp_q <= wrHit ? ipm_pkg::RESP_OKAY : ipm_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bValid_q <= 1'b0;
            end
        end
    end

    always_comb begin
        case (rdIdx)
            ipm_pkg::IDX_POSTED_B: rdByte = postedB_q;             // see R1 see R8
            ipm_pkg::IDX_POSTED_C: rdByte = postedC_q;             // see R1 see R9
            ipm_pkg::IDX_SOFT_CTRL: rdByte = {softPostEn_q, 7'h00}; // see R12
            ipm_pkg::IDX_UNMASK_C: rdByte = unmaskC_q;
            ipm_pkg::IDX_UNMASK_B: rdByte = unmaskB_q;
            ipm_pkg::IDX_IRQ_STATUS: rdByte = irqStatus_q;
            ipm_pkg::IDX_IRQ_MASK: rdByte = irqMask_q;
            default: rdByte = ipm_pkg::RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            arReady_q <= 1'b0;
            rValid_q <= 1'b0;
            rResp_q <= ipm_pkg::RESP_OKAY;
            rData_q <= ipm_pkg::RESET_BYTE;
        end else begin
            arReady_q <= rdFire;
            if (rdDo) begin
                rValid_q <= 1'b1;
                rData_q <= rdByte;
                rResp_q <= rdHit ? ipm_pkg::RESP_OKAY : ipm_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rValid_q <= 1'b0;
            end
        end
    end

    assign postedB_d = post_next(postedB_q, hwPost.b, cpuTake.b, wrByte, ipm_pkg::USED_B, wrB, softPostEn_q);
    assign postedC_d = post_next(postedC_q, hwPost.c, cpuTake.c, wrByte, ipm_pkg::USED_C, wrC, softPostEn_q);

    // Flags post regardless of the unmask bits
    always_ff @(posedge clk) begin
        if (!rstn) begin
            postedB_q <= ipm_pkg::RESET_BYTE;
            postedC_q <= ipm_pkg::RESET_BYTE;
        end else begin
            postedB_q <= postedB_d;                // see R5 see R8
            postedC_q <= postedC_d;                // see R9
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            unmaskB_q <= ipm_pkg::RESET_BYTE;
            unmaskC_q <= ipm_pkg::RESET_BYTE;
            softPostEn_q <= 1'b0;
            irqMask_q <= ipm_pkg::RESET_BYTE;
        end else if (wrDo && wrLane) begin
            case (wrIdx)
                ipm_pkg::IDX_UNMASK_B: unmaskB_q <= wrByte & ipm_pkg::USED_B;  // see R10
                ipm_pkg::IDX_UNMASK_C: unmaskC_q <= wrByte & ipm_pkg::USED_C;  // see R11
                ipm_pkg::IDX_SOFT_CTRL: softPostEn_q <= wrByte[ipm_pkg::SOFT_POST_EN_BIT]; // see R12
                ipm_pkg::IDX_IRQ_MASK: irqMask_q <= wrByte & ipm_pkg::USED_IRQ;
                default: irqMask_q <= irqMask_q;
            endcase
        end
    end

    // Per-bit AND only, so no unmask bit reaches another source
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pending_q <= '0;
        end else begin
            pending_q.b <= postedB_q & unmaskB_q;  // see R5 see R6 see R7 see R13
            pending_q.c <= postedC_q & unmaskC_q;  // see R5 see R6 see R7 see R13
        end
    end

    // Sticky status, write one to clear; a new post in the clearing cycle wins
    always_comb begin
        irqStatus_d = irqStatus_q;
        if (wrDo && wrLane && wrIdx == ipm_pkg::IDX_IRQ_STATUS) begin
            irqStatus_d = irqStatus_d & ~wrByte;
        end
        if ((postedB_d & ~postedB_q) != 8'h00) begin
            irqStatus_d[ipm_pkg::IRQ_POST_B_BIT] = 1'b1;
        end
        if ((postedC_d & ~postedC_q) != 8'h00) begin
            irqStatus_d[ipm_pkg::IRQ_POST_C_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irqStatus_q <= ipm_pkg::RESET_BYTE;
            irq_q <= 1'b0;
        end else begin
            irqStatus_q <= irqStatus_d & ipm_pkg::USED_IRQ;
            irq_q <= |(irqStatus_d & irqMask_q);
        end
    end

    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rresp = rResp_q;
    assign s_axi_rdata = {24'h000000, rData_q};
    assign pending = pending_q;
    assign irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [7:0] hwB;
    logic [7:0] takeB;
    assign hwB = hwPost.b;
    assign takeB = cpuTake.b;

    logic [7:0] hwC;
    logic [7:0] takeC;
    assign hwC = hwPost.c;
    assign takeC = cpuTake.c;

    sequence s_rd_b;
        rdDo && rdIdx == ipm_pkg::IDX_POSTED_B;
    endsequence

    sequence s_wr_b_off;
        wrB && !softPostEn_q;
    endsequence

    sequence s_wr_b_on;
        wrB && softPostEn_q;
    endsequence

    // Flags C share the update function; watching them apart catches a swapped layout
    sequence s_wr_c_off;
        wrC && !softPostEn_q;
    endsequence

    sequence s_wr_c_on;
        wrC && softPostEn_q;
    endsequence

    AST_READ_FLAGS: assert property (s_rd_b |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(postedB_q)) // see R1
        else $error("flag read does not match posted state");

    AST_ZERO_CLEARS: assert property (s_wr_b_off |=> (postedB_q & ~$past(wrByte) & ~$past(hwB)) == 8'h00) // see R2
        else $error("zero write did not clear flag");

    AST_ONE_KEEPS: assert property (s_wr_b_off |=>
        ((postedB_q ^ ((($past(postedB_q) & ~$past(takeB)) | $past(hwB)) & ipm_pkg::USED_B)) & $past(wrByte)) == 8'h00) // see R3
        else $error("one write changed flag with soft-post off");

    AST_ONE_POSTS: assert property (s_wr_b_on |=>
        (postedB_q & $past(wrByte) & ipm_pkg::USED_B) == ($past(wrByte) & ipm_pkg::USED_B)) // see R4
        else $error("soft post did not set flag");

    AST_ZERO_IGNORED: assert property ((s_wr_b_on and takeB == 8'h00) |=> // see R15
        (postedB_q & $past(postedB_q)) == $past(postedB_q))
        else $error("zero write cleared flag with soft-post on");

    AST_PENDING_MASK: assert property (##1 pending.b == ($past(postedB_q) & $past(unmaskB_q)) &&
        pending.c == ($past(postedC_q) & $past(unmaskC_q))) // see R5
        else $error("pending vector is not posted and unmask");

    AST_RESERVED_ZERO: assert property ((postedB_q & ~ipm_pkg::USED_B) == 8'h00 &&
        (postedC_q & ~ipm_pkg::USED_C) == 8'h00 && (unmaskC_q & ~ipm_pkg::USED_C) == 8'h00) // see R8
        else $error("reserved bit set");

    AST_TAKE_CLEARS: assert property (takeB != 8'h00 && !wrB |=> (postedB_q & $past(takeB) & ~$past(hwB)) == 8'h00) // see R14
        else $error("taken interrupt stayed posted");

    AST_HW_POST: assert property (hwB != 8'h00 |=> (postedB_q & $past(hwB)) == ($past(hwB) & ipm_pkg::USED_B)) // see R5
        else $error("hardware post lost");

    AST_WR_RESP: assert property (wrDo |=> s_axi_bvalid ##0 (!s_axi_awready && !s_axi_wready))
        else $error("write response missing");

    AST_IRQ_LEVEL: assert property (##1 irq == |($past(irqStatus_d) & $past(irqMask_q)))
        else $error("irq does not follow masked status");

    AST_C_ZERO_CLEARS: assert property (s_wr_c_off |=> (postedC_q & ~$past(wrByte) & ~$past(hwC)) == 8'h00) // see R2
        else $error("zero write did not clear flag c");

    AST_C_ONE_POSTS: assert property (s_wr_c_on |=> // see R4
        (postedC_q & $past(wrByte) & ipm_pkg::USED_C) == ($past(wrByte) & ipm_pkg::USED_C))
        else $error("soft post did not set flag c");

    AST_C_TAKE_CLEARS: assert property (takeC != 8'h00 && !wrC |=> (postedC_q & $past(takeC) & ~$past(hwC)) == 8'h00) // see R14
        else $error("taken interrupt stayed posted in c");

    AST_C_HW_POST: assert property (hwC != 8'h00 |=> (postedC_q & $past(hwC)) == ($past(hwC) & ipm_pkg::USED_C)) // see R5
        else $error("hardware post lost in c");

    AST_RD_RESP: assert property (rdDo |=> s_axi_rvalid ##0 !s_axi_arready) // see R1
        else $error("read data missing");

    // A rise in the same cycle as a clearing write must still land
    AST_STATUS_SET: assert property ((postedB_d & ~postedB_q) != 8'h00 |=> irqStatus_q[ipm_pkg::IRQ_POST_B_BIT])
        else $error("status bit missed a new post");

    AST_UNMASK_RESERVED: assert property ((unmaskB_q & ~ipm_pkg::USED_B) == 8'h00) // see R10
        else $error("reserved unmask bit set");

    AST_BVALID_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write accepted while response outstanding");

endmodule : ipm_regs

`default_nettype wire

// file: tb/ipm_far_model.sv
/*
 Far side of the posted-flag block: interrupt sources that raise one-cycle
 post strobes, and a CPU that takes one pending interrupt at a time.
 Assumes the same clock and reset as the register block.
*/
`default_nettype none

module ipm_far_model (
    input wire logic clk,                      // System clock
    input wire logic rstn,                     // Synchronous reset, active low
    input wire ipm_pkg::ipm_flags_t postReq,   // Posts asked for by the bench
    input wire logic takeEn,                   // CPU accepts interrupts
    input wire ipm_pkg::ipm_flags_t pending,   // Pending vector from the block
    output var ipm_pkg::ipm_flags_t hwPost,    // Source post strobes
    output var ipm_pkg::ipm_flags_t cpuTake    // CPU take strobes
);
    logic [1:0] gap_q;
    logic [15:0] pendVec;

    assign pendVec = pending;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hwPost <= '0;
        end else begin
            hwPost <= postReq;
        end
    end

    // Gap lets a cleared flag leave pending before the next pick
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cpuTake <= '0;
            gap_q <= 2'h0;
        end else if (takeEn && pendVec != 16'h0000 && gap_q == 2'h0) begin
            cpuTake <= ipm_pkg::ipm_flags_t'(pendVec & (~pendVec + 16'h0001));
            gap_q <= 2'h3;
        end else begin
            cpuTake <= '0;
            gap_q <= (gap_q == 2'h0) ? 2'h0 : gap_q - 2'h1;
        end
    end
endmodule : ipm_far_model

`default_nettype wire

// file: tb/tb_irq_post_mask_regs.sv
/*
 Self-checking bench for the posted-flag and unmask register block.
 Assumes an AXI4-Lite master in the bench and the far-side model beside it.
*/
`default_nettype none

`define IPM_CHK(got, exp, msg) begin cmpCount++; if ((got) !== (exp)) begin numErrors++; \
    $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp); end end

module tb_irq_post_mask_regs;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic wr; logic [9:0] idx; logic [7:0] d; logic [7:0] exp; logic [1:0] rsp;} ipm_row_t;
    localparam logic [1:0] OK = ipm_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = ipm_pkg::RESP_SLVERR;
    logic clk = 1'b0;
    logic rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, takeEn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    ipm_pkg::ipm_flags_t hwPost, cpuTake, pending, postReq;
    int numErrors = 0;
    int cmpCount = 0;
    int cycles = 0;
    ipm_row_t rows [0:14] = '{
        '{1'b0, ipm_pkg::IDX_POSTED_C, 8'h00, 8'h00, OK},
        '{1'b0, ipm_pkg::IDX_UNMASK_B, 8'h00, 8'h00, OK},
        '{1'b0, ipm_pkg::IDX_SOFT_CTRL, 8'h00, 8'h00, OK},
        '{1'b1, ipm_pkg::IDX_UNMASK_B, 8'hFF, 8'h7F, OK},
        '{1'b1, ipm_pkg::IDX_UNMASK_C, 8'hFF, 8'h16, OK},
        '{1'b1, ipm_pkg::IDX_SOFT_CTRL, 8'h7F, 8'h00, OK},
        '{1'b1, ipm_pkg::IDX_SOFT_CTRL, 8'hFF, 8'h80, OK},
        '{1'b1, ipm_pkg::IDX_POSTED_B, 8'hFF, 8'h7F, OK},
        '{1'b1, ipm_pkg::IDX_POSTED_C, 8'hFF, 8'h16, OK},
        '{1'b1, ipm_pkg::IDX_POSTED_B, 8'h00, 8'h7F, OK},
        '{1'b1, ipm_pkg::IDX_SOFT_CTRL, 8'h00, 8'h00, OK},
        '{1'b1, ipm_pkg::IDX_POSTED_B, 8'hFF, 8'h7F, OK},
        '{1'b1, ipm_pkg::IDX_POSTED_B, 8'h00, 8'h00, OK},
        '{1'b1, ipm_pkg::IDX_POSTED_C, 8'h00, 8'h00, OK},
        '{1'b1, 10'h100, 8'hFF, 8'h00, ERR}
    };

    ipm_regs #(.ADDR_W(12)) dut (
        .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .hwPost(hwPost), .cpuTake(cpuTake), .pending(pending), .irq(irq)
    );

    ipm_far_model far (
        .clk(clk), .rstn(rstn), .postReq(postReq), .takeEn(takeEn),
        .pending(pending), .hwPost(hwPost), .cpuTake(cpuTake)
    );

    always #50 clk = ~clk;

    task automatic print_verdict;
        $display("counts: compares %0d mismatches %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Hangs end here rather than stalling the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            numErrors++;
            print_verdict();
        end
    end

    task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] rsp);
        logic done;
        done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                done = 1'b1;
                s_axi_bready <= 1'b0;
                `IPM_CHK(s_axi_bresp, rsp, "bresp")
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [9:0] idx, input logic [7:0] exp, input logic [1:0] rsp);
        logic done;
        done = 1'b0;
        @(posedge clk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                done = 1'b1;
                s_axi_rready <= 1'b0;
                `IPM_CHK(s_axi_rdata, {24'h000000, exp}, "rdata")
                `IPM_CHK(s_axi_rresp, rsp, "rresp")
            end
        end
    endtask : axi_rd

    task automatic post(input logic [7:0] b, input logic [7:0] c);
        @(posedge clk);
        postReq <= ipm_pkg::ipm_flags_t'({b, c});
        @(posedge clk);
        postReq <= '0;
        repeat (4) @(posedge clk);
    endtask : post

    initial begin
        rstn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, takeEn} = 6'h00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        postReq = '0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `IPM_CHK(pending, 16'h0000, "pending at reset")
        `IPM_CHK(irq, 1'b0, "irq at reset")
        for (int i = 0; i < 15; i++) begin
            if (rows[i].wr) axi_wr(rows[i].idx, rows[i].d, rows[i].rsp);
            axi_rd(rows[i].idx, rows[i].exp, rows[i].rsp);
        end
        $display("test register rows done");
        // Masked sources still post; only their own unmask bit matters
        axi_wr(ipm_pkg::IDX_UNMASK_B, 8'h01, OK);
        axi_wr(ipm_pkg::IDX_UNMASK_C, 8'h00, OK);
        post(8'h03, 8'h02);
        axi_rd(ipm_pkg::IDX_POSTED_B, 8'h03, OK);
        `IPM_CHK(pending.b, 8'h01, "pending b")
        `IPM_CHK(pending.c, 8'h00, "pending c masked")
        axi_wr(ipm_pkg::IDX_UNMASK_C, 8'h02, OK);
        repeat (3) @(posedge clk);
        `IPM_CHK(pending.c, 8'h02, "pending c unmasked")
        $display("test mask done");
        takeEn <= 1'b1;
        repeat (12) @(posedge clk);
        takeEn <= 1'b0;
        axi_rd(ipm_pkg::IDX_POSTED_B, 8'h02, OK);
        axi_rd(ipm_pkg::IDX_POSTED_C, 8'h00, OK);
        `IPM_CHK(pending, 16'h0000, "pending after take")
        $display("test take done");
        axi_wr(ipm_pkg::IDX_IRQ_STATUS, 8'h03, OK);
        axi_rd(ipm_pkg::IDX_IRQ_STATUS, 8'h00, OK);
        `IPM_CHK(irq, 1'b0, "irq cleared")
        axi_wr(ipm_pkg::IDX_IRQ_MASK, 8'h01, OK);
        post(8'h04, 8'h00);
        `IPM_CHK(irq, 1'b1, "irq raised")
        axi_rd(ipm_pkg::IDX_IRQ_STATUS, 8'h01, OK);
        axi_wr(ipm_pkg::IDX_IRQ_MASK, 8'h00, OK);
        repeat (2) @(posedge clk);
        `IPM_CHK(irq, 1'b0, "irq masked")
        axi_wr(ipm_pkg::IDX_IRQ_STATUS, 8'h01, OK);
        axi_rd(ipm_pkg::IDX_IRQ_STATUS, 8'h00, OK);
        $display("test interrupt done");
        // Flags C drive status bit 1; a write with lane 0 off must change nothing
        axi_wr(ipm_pkg::IDX_IRQ_MASK, 8'h02, OK);
        axi_wr(ipm_pkg::IDX_UNMASK_C, 8'h10, OK);
        post(8'h00, 8'h10);
        `IPM_CHK(irq, 1'b1, "irq from flags c")
        `IPM_CHK(pending.c, 8'h10, "pending c gpio")
        s_axi_wstrb <= 4'h0;
        axi_wr(ipm_pkg::IDX_UNMASK_B, 8'h7E, OK);
        s_axi_wstrb <= 4'hF;
        axi_rd(ipm_pkg::IDX_UNMASK_B, 8'h01, OK);
        $display("test flags c done");
        // Mid-run reset while flags, masks and irq are all non-zero
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `IPM_CHK(pending, 16'h0000, "pending after reset")
        `IPM_CHK(irq, 1'b0, "irq after reset")
        axi_rd(ipm_pkg::IDX_POSTED_C, 8'h00, OK);
        axi_rd(ipm_pkg::IDX_UNMASK_C, 8'h00, OK);
        $display("test reset done");
        print_verdict();
    end
endmodule : tb_irq_post_mask_regs

`default_nettype wire
